// *** dmx_pkg.sv ***
package dmx_pkg;
    // ----------------------------------------
    // Instruction word layout
    // ----------------------------------------
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int LIT_TOP_POS = 12;
    localparam int DIR_POS = 7;
    localparam logic [1:0] LIT_TOP_CODE = 2'h3;
    localparam logic [1:0] LIT_MID_CODE = 2'h0;
    localparam logic [5:0] COPY_CODE = 6'h08;
    localparam logic [5:0] STORE_CODE = 6'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [ADDR_W-1:0] ZERO_ADDR = 7'h00;

    // ----------------------------------------
    // Instruction cycle phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        DMX_PH_DECODE = 2'b00,
        DMX_PH_READ = 2'b01,
        DMX_PH_PROC = 2'b10,
        DMX_PH_WRITE = 2'b11
    } dmx_phase_t;
endpackage

// *** dmx_data_move_exec.sv ***
`timescale 1ns/1ps
// Functional notes
// - Literal-load word 11_00xx writes low byte to accumulator, flags untouched.
// - Two don't-care bits of literal-load are ignored; either value accepted.
// - Copy-register word 00_1000 reads addressed file register for destination.
// - Copy destination bit 0 selects accumulator, 1 writes same register back.
// - Copy sets zero flag when moved value is zero, clears it otherwise.
module dmx_data_move_exec
    import dmx_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic instrValid,
    input wire logic [INSTR_W-1:0] instrWord,
    input wire logic [DATA_W-1:0] fileRdData,
    output logic instrReady,
    output logic [ADDR_W-1:0] fileAddr,
    output logic fileRdEn,
    output logic fileWrEn,
    output logic [DATA_W-1:0] fileWrData,
    output logic [DATA_W-1:0] accum,
    output logic zeroFlag,
    output logic zeroFlagWrEn,
    output logic instrDone
);
    // ----------------------------------------
    // Phase sequencer and instruction latch
    // ----------------------------------------
    dmx_phase_t phase_r, phase_nxt;
    logic busy_r;
    logic [INSTR_W-1:0] ir_r;
    logic [DATA_W-1:0] rdHold_r;
    logic [DATA_W-1:0] accum_r;
    logic zero_r;
    logic fileWr_r;
    logic [DATA_W-1:0] fileWrData_r;
    logic zeroWr_r;
    logic done_r;

    wire logic take = instrValid && !busy_r;
    assign instrReady = !busy_r;

    always_comb begin
        case (phase_r)
            DMX_PH_DECODE: phase_nxt = DMX_PH_READ;
            DMX_PH_READ: phase_nxt = DMX_PH_PROC;
            DMX_PH_PROC: phase_nxt = DMX_PH_WRITE;
            DMX_PH_WRITE: phase_nxt = DMX_PH_DECODE;
            default: phase_nxt = DMX_PH_DECODE;
        endcase
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic [5:0] opHigh = ir_r[INSTR_W-1:INSTR_W-6];
    wire logic isLit = (ir_r[INSTR_W-1:LIT_TOP_POS] == LIT_TOP_CODE) &&
                       (ir_r[LIT_TOP_POS-1:LIT_TOP_POS-2] == LIT_MID_CODE);
    wire logic isCopy = (opHigh == COPY_CODE);
    wire logic isStore = (opHigh == STORE_CODE) && ir_r[DIR_POS];
    wire logic dirBit = ir_r[DIR_POS];
    wire logic [DATA_W-1:0] literal = ir_r[DATA_W-1:0];
    wire logic inRead = busy_r && (phase_r == DMX_PH_READ);
    wire logic inWrite = busy_r && (phase_r == DMX_PH_WRITE);
    wire logic movedZero = (rdHold_r == ZERO_BYTE);

    assign fileAddr = (busy_r || fileWr_r) ? ir_r[ADDR_W-1:0] : ZERO_ADDR;
    assign fileRdEn = inRead && isCopy;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_r <= DMX_PH_DECODE;
            busy_r <= 1'b0;
            ir_r <= '0;
        end else begin
            if (take) begin
                busy_r <= 1'b1;
                ir_r <= instrWord;
                phase_r <= DMX_PH_READ;
            end else if (busy_r) begin
                phase_r <= phase_nxt;
                if (phase_r == DMX_PH_WRITE) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdHold_r <= ZERO_BYTE;
        end else if (fileRdEn) begin
            rdHold_r <= fileRdData;
        end
    end

    // ----------------------------------------
    // Write phase
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            accum_r <= ZERO_BYTE;
            zero_r <= 1'b0;
            fileWr_r <= 1'b0;
            fileWrData_r <= ZERO_BYTE;
            zeroWr_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            fileWr_r <= 1'b0;
            zeroWr_r <= 1'b0;
            done_r <= inWrite;
            if (inWrite) begin
                if (isLit) begin
                    accum_r <= literal;
                end
                if (isCopy) begin
                    if (dirBit) begin
                        fileWr_r <= 1'b1;
                        fileWrData_r <= rdHold_r;
                    end else begin
                        accum_r <= rdHold_r;
                    end
                    zero_r <= movedZero;
                    zeroWr_r <= 1'b1;
                end
                if (isStore) begin
                    fileWr_r <= 1'b1;
                    fileWrData_r <= accum_r;
                end
            end
        end
    end

    assign accum = accum_r;
    assign zeroFlag = zero_r;
    assign zeroFlagWrEn = zeroWr_r;
    assign fileWrEn = fileWr_r;
    assign fileWrData = fileWrData_r;
    assign instrDone = done_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_lit_load;
        @(posedge clk) disable iff (!rstn)
        (inWrite && isLit) |=> (accum_r == $past(literal)) && !zeroWr_r;
    endproperty
    a_lit_load: assert property (p_lit_load) else $error("literal not loaded");

    property p_lit_dontcare;
        @(posedge clk) disable iff (!rstn)
        (inWrite && ir_r[INSTR_W-1:LIT_TOP_POS] == LIT_TOP_CODE &&
         ir_r[LIT_TOP_POS-1:LIT_TOP_POS-2] == LIT_MID_CODE) |=>
            accum_r == $past(ir_r[DATA_W-1:0]);
    endproperty
    a_lit_dontcare: assert property (p_lit_dontcare) else $error("literal dont care");

    property p_copy_read;
        @(posedge clk) disable iff (!rstn)
        (take && instrWord[INSTR_W-1:INSTR_W-6] == COPY_CODE) |=> fileRdEn
            ##0 (fileAddr == $past(instrWord[ADDR_W-1:0]));
    endproperty
    a_copy_read: assert property (p_copy_read) else $error("copy read missing");

    property p_copy_dest;
        @(posedge clk) disable iff (!rstn)
        (inWrite && isCopy) |=> (fileWr_r == $past(dirBit)) &&
            ($past(dirBit) ? fileWrData_r == $past(rdHold_r) : accum_r == $past(rdHold_r));
    endproperty
    a_copy_dest: assert property (p_copy_dest) else $error("copy destination wrong");

    property p_copy_zero;
        @(posedge clk) disable iff (!rstn)
        (fileRdEn) ##3 1 |-> zeroWr_r && (zero_r == ($past(rdHold_r, 2) == ZERO_BYTE));
    endproperty
    a_copy_zero: assert property (p_copy_zero) else $error("zero flag wrong");

    property p_store;
        @(posedge clk) disable iff (!rstn)
        (inWrite && isStore) |=> fileWr_r && !zeroWr_r &&
            (fileWrData_r == $past(accum_r)) && $stable(accum_r);
    endproperty
    a_store: assert property (p_store) else $error("store wrong");

    property p_four_phase;
        @(posedge clk) disable iff (!rstn)
        take |=> busy_r [*3] ##1 !busy_r ##0 instrDone;
    endproperty
    a_four_phase: assert property (p_four_phase) else $error("cycle length wrong");

    property p_flags_kept;
        @(posedge clk) disable iff (!rstn)
        (inWrite && !isCopy) |=> !zeroWr_r && $stable(zero_r);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flag changed");

    property p_wr_addr;
        @(posedge clk) disable iff (!rstn)
        (inWrite && (isStore || (isCopy && dirBit))) |=> fileWrEn &&
            (fileAddr == $past(ir_r[ADDR_W-1:0]));
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address wrong");

    property p_ir_hold;
        @(posedge clk) disable iff (!rstn)
        busy_r |=> $stable(ir_r);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("word changed while busy");

    c_lit: cover property (@(posedge clk) disable iff (!rstn) inWrite && isLit);
    c_copy_w: cover property (@(posedge clk) disable iff (!rstn) inWrite && isCopy && !dirBit);
    c_copy_f: cover property (@(posedge clk) disable iff (!rstn) inWrite && isCopy && dirBit);
    c_store: cover property (@(posedge clk) disable iff (!rstn) inWrite && isStore);
    c_nop: cover property (@(posedge clk) disable iff (!rstn)
        inWrite && !isLit && !isCopy && !isStore);
endmodule

// *** dmx_data_move_exec_test.sv ***
`timescale 1ns/1ps
module dmx_data_move_exec_test;
    import dmx_pkg::*;
    logic clk, rstn, instrValid, instrReady, fileRdEn, fileWrEn;
    logic zeroFlag, zeroFlagWrEn, instrDone, sawRd, sawWr, sawZw;
    logic [INSTR_W-1:0] instrWord;
    logic [DATA_W-1:0] fileRdData, fileWrData, accum;
    logic [ADDR_W-1:0] fileAddr, rdAddr, wrAddr;
    int failCount = 0;
    int testsRun = 0;
    int cycles = 0;

    dmx_data_move_exec u_dmx_data_move_exec (.clk(clk), .rstn(rstn), .instrValid(instrValid),
        .instrWord(instrWord), .fileRdData(fileRdData), .instrReady(instrReady),
        .fileAddr(fileAddr), .fileRdEn(fileRdEn), .fileWrEn(fileWrEn),
        .fileWrData(fileWrData), .accum(accum), .zeroFlag(zeroFlag),
        .zeroFlagWrEn(zeroFlagWrEn), .instrDone(instrDone));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic finalReport();
        $display("Comparisons %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 2000) begin
            failCount++;
            finalReport();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One instruction, strobes gathered until retire
    task automatic run(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] rd);
        int n;
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= w;
        fileRdData <= rd;
        @(posedge clk);
        instrValid <= 1'b0;
        {sawRd, sawWr, sawZw} = 3'b000;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (fileRdEn === 1'b1) rdAddr = fileAddr;
            if (fileWrEn === 1'b1) wrAddr = fileAddr;
            sawRd = sawRd | (fileRdEn === 1'b1);
            sawWr = sawWr | (fileWrEn === 1'b1);
            sawZw = sawZw | (zeroFlagWrEn === 1'b1);
        end while (instrDone !== 1'b1 && n < 8);
        chk("instrDone", 8'h01, {7'h00, instrDone});
    endtask

    task automatic testLiteral();
        run(14'h335A, 8'h00);
        chk("accum", 8'h5A, accum);
        chk("writes", 8'h00, {6'h00, sawWr, sawZw});
        run(14'h3000, 8'h00);
        chk("accum", 8'h00, accum);
        $display("testLiteral done");
    endtask

    task automatic testCopyAcc();
        run(14'h30FF, 8'h00);
        chk("accum", 8'hFF, accum);
        run({COPY_CODE, 1'b0, 7'h7F}, 8'h00);
        chk("rdAddr", 8'h7F, {1'b0, rdAddr});
        chk("accum", 8'h00, accum);
        chk("zeroFlag", 8'h01, {7'h00, zeroFlag});
        chk("writes", 8'h05, {5'h00, sawRd, sawWr, sawZw});
        $display("testCopyAcc done");
    endtask

    task automatic testCopyBack();
        run({COPY_CODE, 1'b1, 7'h15}, 8'hA5);
        chk("fileWrData", 8'hA5, fileWrData);
        chk("wrAddr", 8'h15, {1'b0, wrAddr});
        chk("accum", 8'h00, accum);
        chk("zeroFlag", 8'h00, {7'h00, zeroFlag});
        chk("writes", 8'h07, {5'h00, sawRd, sawWr, sawZw});
        $display("testCopyBack done");
    endtask

    task automatic testStore();
        run(14'h30C3, 8'h00);
        run({STORE_CODE, 1'b1, 7'h2A}, 8'h00);
        chk("fileWrData", 8'hC3, fileWrData);
        chk("wrAddr", 8'h2A, {1'b0, wrAddr});
        chk("writes", 8'h02, {6'h00, sawWr, sawZw});
        chk("zeroFlag", 8'h00, {7'h00, zeroFlag});
        $display("testStore done");
    endtask

    // Store word without bit seven, then a word offered while busy
    task automatic testRefuse();
        run(14'h0000, 8'h00);
        chk("writes", 8'h00, {5'h00, sawRd, sawWr, sawZw});
        chk("accum", 8'hC3, accum);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= 14'h3011;
        @(posedge clk);
        instrWord <= 14'h3022;
        @(negedge clk);
        chk("instrReady", 8'h00, {7'h00, instrReady});
        @(posedge clk);
        @(posedge clk);
        @(posedge clk);
        instrValid <= 1'b0;
        @(negedge clk);
        chk("instrDone", 8'h01, {7'h00, instrDone});
        chk("accum", 8'h11, accum);
        $display("testRefuse done");
    endtask

    initial begin
        rstn = 1'b0;
        instrValid = 1'b0;
        instrWord = 14'h0000;
        fileRdData = 8'h00;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("instrReady", 8'h01, {7'h00, instrReady});
        testLiteral();
        testCopyAcc();
        testCopyBack();
        testStore();
        testRefuse();
        finalReport();
    end
endmodule
